// ### mpo_ovr_if.sv
// Override fields between the register file and the sync stage
`timescale 1ns/1ps
`default_nettype none
interface mpo_ovr_if;
    logic [7:0] shd_sel;
    logic [7:0] shd_lvl;
    logic       sync_en;
    logic       sync_pt;
    logic [7:0] act_sel;
    logic [7:0] act_lvl;
    modport ctl (output shd_sel, shd_lvl, sync_en, sync_pt,
                 input  act_sel, act_lvl);
    modport syn (input  shd_sel, shd_lvl, sync_en, sync_pt,
                 output act_sel, act_lvl);
endinterface : mpo_ovr_if
`default_nettype wire

// ### mpo_ovr_sync.sv
// Applies written override fields at once or at time-base sync points
`timescale 1ns/1ps
`default_nettype none
module mpo_ovr_sync (
    input  wire logic CLK_IN,
    input  wire logic RST_IN,
    mpo_ovr_if.syn    ovr
);
    import mpo_pkg::*;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ovr.act_sel <= RST_OVR_SEL;
            ovr.act_lvl <= RST_OVR_LVL;
        end else if (!ovr.sync_en || ovr.sync_pt) begin
            ovr.act_sel <= ovr.shd_sel;
            ovr.act_lvl <= ovr.shd_lvl;
        end
    end

endmodule : mpo_ovr_sync
`default_nettype wire

// ### mpo_pair_stage.sv
// Dead time, fault forcing and polarity for one output pair
`timescale 1ns/1ps
`default_nettype none
module mpo_pair_stage (
    input  wire logic       CLK_IN,
    input  wire logic       RST_IN,
    input  wire logic       COMP_IN,
    input  wire logic       ODD_REQ_IN,
    input  wire logic       EVEN_REQ_IN,
    input  wire logic [7:0] DEAD_IN,
    input  wire logic [1:0] FORCE_OFF_IN,
    input  wire logic [1:0] POL_IN,
    output logic      [1:0] ACT_OUT,
    output logic      [1:0] PIN_OUT
);
    import mpo_pkg::*;

    logic [7:0] cnt_o_q;
    logic [7:0] cnt_e_q;
    logic       on_o_q;
    logic       on_e_q;
    logic       on_o_d;
    logic       on_e_d;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN || !ODD_REQ_IN || on_e_q) begin
            cnt_o_q <= 8'h00;
        end else if (cnt_o_q != DEAD_IN) begin
            cnt_o_q <= cnt_o_q + 8'h01;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN || !EVEN_REQ_IN || on_o_q) begin
            cnt_e_q <= 8'h00;
        end else if (cnt_e_q != DEAD_IN) begin
            cnt_e_q <= cnt_e_q + 8'h01;
        end
    end

    always_comb begin
        on_o_d = ODD_REQ_IN &
                 (!COMP_IN || (cnt_o_q == DEAD_IN && !on_e_q));
        on_e_d = EVEN_REQ_IN &
                 (!COMP_IN || (cnt_e_q == DEAD_IN && !on_o_q && !on_o_d));
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            on_o_q <= 1'b0;
            on_e_q <= 1'b0;
        end else begin
            on_o_q <= on_o_d;
            on_e_q <= on_e_d;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ACT_OUT <= 2'h0;
            PIN_OUT <= 2'h0;
        end else begin
            ACT_OUT <= {on_o_d, on_e_d} & ~FORCE_OFF_IN;
            PIN_OUT <= ({on_o_d, on_e_d} & ~FORCE_OFF_IN) ^ POL_IN;
        end
    end

endmodule : mpo_pair_stage
`default_nettype wire

// ### mpo_pkg.sv
// Constants and types shared by the motor PWM output-control block
package mpo_pkg;

    localparam int CNT_W  = 12;
    localparam int NPAIR  = 4;
    localparam int NPIN   = 8;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL0   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PERIOD  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CTRL1   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FLTCFG  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_OVR_SEL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_OVR_LVL = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_DEAD    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_DUTY0   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_DUTY3   = 8'h2C;

    // Field positions
    localparam int CTRL0_MODE_LSB = 0;
    localparam int CTRL0_RUN      = 2;
    localparam int CTRL0_IRQ_EN   = 3;
    localparam int CTRL1_SYNC     = 0;
    localparam int CTRL1_PMOD_LSB = 4;
    localparam int FLT_SCOPE      = 0;
    localparam int FLT_BRK_EN     = 1;
    localparam int STAT_FAULT     = 12;
    localparam int STAT_PIN_LSB   = 16;

    // Timebase mode codes
    localparam logic [1:0] TB_MODE_EDGE   = 2'h0;
    localparam logic [1:0] TB_MODE_SINGLE = 2'h1;
    localparam logic [1:0] TB_MODE_CENTER = 2'h2;

    // Reset values
    localparam logic [7:0]       RST_OVR_SEL = 8'hFF;
    localparam logic [7:0]       RST_OVR_LVL = 8'h00;
    localparam logic [CNT_W-1:0] RST_PERIOD  = 12'hFFF;
    localparam logic [7:0]       RST_DEAD    = 8'h04;

    // Outputs forced inactive by a fault: ALL when the scope bit is set, PART when it is clear
    localparam logic [7:0] FLT_MASK_ALL  = 8'hFF;
    localparam logic [7:0] FLT_MASK_PART = 8'h3F;

    typedef enum logic [1:0] {
        TB_UP   = 2'b01,
        TB_DOWN = 2'b10
    } mpo_dir_e;

endpackage : mpo_pkg

// ### mpo_power_stage.sv
// Power stage model: two switches per leg, flags shoot-through
`timescale 1ns/1ps
`default_nettype none
module mpo_power_stage (
    input  wire logic       CLK_IN,
    input  wire logic       RST_IN,
    input  wire logic [7:0] PIN_IN,
    input  wire logic [7:0] POL_IN,
    input  wire logic [3:0] COMP_IN,
    output logic            SHOOT_OUT
);
    logic [7:0] sw_on;
    logic [3:0] legs;
    assign sw_on = PIN_IN ^ POL_IN;
    assign legs  = {sw_on[7] & sw_on[6], sw_on[5] & sw_on[4],
                    sw_on[3] & sw_on[2], sw_on[1] & sw_on[0]};
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            SHOOT_OUT <= 1'b0;
        end else if (|(legs & COMP_IN)) begin
            SHOOT_OUT <= 1'b1;
        end
    end
endmodule : mpo_power_stage
`default_nettype wire

// ### mpo_top.sv
// Motor PWM output control: timebase, single pulse, override, fault
//
// Summary of operation
// - Single pulse only in edge-aligned timing, mode 01.
// - Single pulse: enabled outputs go active as soon as run is set.
// - Single pulse: a channel goes inactive when count meets its duty.
// - Period match: clear count, outputs inactive, clear run, optional pulse.
// - Period and duty stay after a pulse; setting run repeats it.
// - Eight-bit override select and level fields, one bit per pin.
// - Select set passes duty output; clear uses level bit.
// - Overridden pin is active for level 1, inactive for level 0.
// - Complementary even overridden active follows odd's complement.
// - With sync enabled, override changes wait for time-base sync points.
// - Edge-aligned sync point is count equal to zero.
// - Center-aligned sync at count zero and count equal period.
// - Complementary even never active while odd is active.
// - Dead time kept under override.
// - Any fault input active puts affected outputs inactive.
// - Scope bit 1: all eight outputs forced inactive during a fault.
// - Scope bit 0: only outputs 5..0 forced; 7 and 6 run on.
// - Breakpoint fault enable makes a debug halt count as a fault.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mpo_top (
    input  wire logic                      CORE_CLK_IN,
    input  wire logic                      RST_IN,
    input  wire logic                      PSEL_IN,
    input  wire logic                      PENABLE_IN,
    input  wire logic                      PWRITE_IN,
    input  wire logic [mpo_pkg::ADDR_W-1:0] PADDR_IN,
    input  wire logic [31:0]               PWDATA_IN,
    output logic      [31:0]               PRDATA_OUT,
    output logic                           PREADY_OUT,
    output logic                           PSLVERR_OUT,
    input  wire logic                      FAULT_A_IN,
    input  wire logic                      FAULT_B_IN,
    input  wire logic                      DEBUG_HALT_IN,
    input  wire logic [mpo_pkg::NPIN-1:0]  POLARITY_IN,
    output logic      [mpo_pkg::NPIN-1:0]  PWM_OUT,
    output logic                           PERIOD_EVT_OUT
);
    import mpo_pkg::*;

    // Control registers
    logic [1:0]       timebase_mode_sel_q;
    logic             timebase_run_q;
    logic             period_evt_en_q;
    logic [CNT_W-1:0] period_value_q;
    logic             override_sync_en_q;
    logic [3:0]       pair_mode_q;
    logic             fault_scope_all_q;
    logic             breakpoint_fault_en_q;
    logic [7:0]       override_select_q;
    logic [7:0]       override_level_q;
    logic [7:0]       dead_time_q;
    logic [CNT_W-1:0] duty_value_q [NPAIR];

    // Timebase
    logic [CNT_W-1:0] timebase_count_q;
    mpo_dir_e         dir_q;
    logic             period_match;
    logic             is_center;
    logic             is_single;
    logic             run_set;
    logic [3:0]       pulse_q;
    logic [3:0]       odd_raw;

    // Bus decode
    logic             apb_setup;
    logic             apb_wr;
    logic             addr_hit;
    logic [31:0]      rd_mux;

    // Fault path
    logic [2:0]       sync1_q;
    logic [2:0]       sync2_q;
    logic             fault_active;
    logic [7:0]       force_off;

    // Output path
    logic [7:0]       pin_req;
    logic [7:0]       pin_act;

    mpo_ovr_if ovr ();

    assign apb_setup = PSEL_IN && !PENABLE_IN;
    assign apb_wr    = PSEL_IN && PENABLE_IN && PWRITE_IN && addr_hit;
    assign PREADY_OUT = 1'b1;

    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0000_0000;
        unique case (PADDR_IN)
            OFS_CTRL0: begin
                rd_mux[CTRL0_MODE_LSB +: 2] = timebase_mode_sel_q;
                rd_mux[CTRL0_RUN]           = timebase_run_q;
                rd_mux[CTRL0_IRQ_EN]        = period_evt_en_q;
            end
            OFS_PERIOD: begin
                rd_mux[CNT_W-1:0] = period_value_q;
            end
            OFS_CTRL1: begin
                rd_mux[CTRL1_SYNC]           = override_sync_en_q;
                rd_mux[CTRL1_PMOD_LSB +: 4]  = pair_mode_q;
            end
            OFS_FLTCFG: begin
                rd_mux[FLT_SCOPE]  = fault_scope_all_q;
                rd_mux[FLT_BRK_EN] = breakpoint_fault_en_q;
            end
            OFS_OVR_SEL: begin
                rd_mux[7:0] = override_select_q;
            end
            OFS_OVR_LVL: begin
                rd_mux[7:0] = override_level_q;
            end
            OFS_DEAD: begin
                rd_mux[7:0] = dead_time_q;
            end
            OFS_STATUS: begin
                rd_mux[CNT_W-1:0]        = timebase_count_q;
                rd_mux[STAT_FAULT]       = fault_active;
                rd_mux[STAT_PIN_LSB +: 8] = pin_act;
            end
            default: begin
                if (PADDR_IN >= OFS_DUTY0 && PADDR_IN <= OFS_DUTY3
                    && PADDR_IN[1:0] == 2'h0) begin
                    rd_mux[CNT_W-1:0] = duty_value_q[PADDR_IN[3:2]];
                end else begin
                    addr_hit = 1'b0;
                end
            end
        endcase
    end

    // Captured at setup, so zero wait states
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else if (apb_setup) begin
            PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
            PSLVERR_OUT <= !addr_hit;
        end
    end

    assign is_single = (timebase_mode_sel_q == TB_MODE_SINGLE);
    assign is_center = timebase_mode_sel_q[1];
    assign run_set   = apb_wr && PADDR_IN == OFS_CTRL0
                       && PWDATA_IN[CTRL0_RUN]
                       && PWDATA_IN[CTRL0_MODE_LSB +: 2] == TB_MODE_SINGLE;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            timebase_mode_sel_q <= TB_MODE_EDGE;
            period_evt_en_q     <= 1'b0;
        end else if (apb_wr && PADDR_IN == OFS_CTRL0) begin
            timebase_mode_sel_q <= PWDATA_IN[CTRL0_MODE_LSB +: 2];
            period_evt_en_q     <= PWDATA_IN[CTRL0_IRQ_EN];
        end
    end

    // Run cleared at single-pulse end; a write in that cycle wins
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            timebase_run_q <= 1'b0;
        end else if (apb_wr && PADDR_IN == OFS_CTRL0) begin
            timebase_run_q <= PWDATA_IN[CTRL0_RUN];
        end else if (is_single && period_match) begin
            timebase_run_q <= 1'b0;
        end
    end

    // Period and duty only change on writes
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            period_value_q <= RST_PERIOD;
        end else if (apb_wr && PADDR_IN == OFS_PERIOD) begin
            period_value_q <= PWDATA_IN[CNT_W-1:0];
        end
    end

    generate
        for (genvar p = 0; p < NPAIR; p++) begin : g_duty
            always_ff @(posedge CORE_CLK_IN) begin
                if (RST_IN) begin
                    duty_value_q[p] <= '0;
                end else if (apb_wr && PADDR_IN ==
                             OFS_DUTY0 + ADDR_W'(4 * p)) begin
                    duty_value_q[p] <= PWDATA_IN[CNT_W-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            override_sync_en_q <= 1'b0;
            pair_mode_q        <= 4'h0;
        end else if (apb_wr && PADDR_IN == OFS_CTRL1) begin
            override_sync_en_q <= PWDATA_IN[CTRL1_SYNC];
            pair_mode_q        <= PWDATA_IN[CTRL1_PMOD_LSB +: 4];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            fault_scope_all_q     <= 1'b1;
            breakpoint_fault_en_q <= 1'b0;
        end else if (apb_wr && PADDR_IN == OFS_FLTCFG) begin
            fault_scope_all_q     <= PWDATA_IN[FLT_SCOPE];
            breakpoint_fault_en_q <= PWDATA_IN[FLT_BRK_EN];
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            override_select_q <= RST_OVR_SEL;
            override_level_q  <= RST_OVR_LVL;
            dead_time_q       <= RST_DEAD;
        end else if (apb_wr) begin
            if (PADDR_IN == OFS_OVR_SEL) begin
                override_select_q <= PWDATA_IN[7:0];
            end
            if (PADDR_IN == OFS_OVR_LVL) begin
                override_level_q <= PWDATA_IN[7:0];
            end
            if (PADDR_IN == OFS_DEAD) begin
                dead_time_q <= PWDATA_IN[7:0];
            end
        end
    end

    // Single pulse counts up like edge-aligned
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN || !timebase_run_q) begin
            timebase_count_q <= '0;
            dir_q            <= TB_UP;
        end else begin
            unique case (dir_q)
                TB_UP: begin
                    if (timebase_count_q >= period_value_q) begin
                        if (is_center && period_value_q != '0) begin
                            dir_q            <= TB_DOWN;
                            timebase_count_q <= period_value_q - 1'b1;
                        end else begin
                            timebase_count_q <= '0;
                        end
                    end else begin
                        timebase_count_q <= timebase_count_q + 1'b1;
                    end
                end
                TB_DOWN: begin
                    if (timebase_count_q == '0) begin
                        dir_q            <= TB_UP;
                        timebase_count_q <= timebase_count_q + 1'b1;
                    end else begin
                        timebase_count_q <= timebase_count_q - 1'b1;
                    end
                end
            endcase
        end
    end

    assign period_match = timebase_run_q && dir_q == TB_UP
                          && timebase_count_q == period_value_q;

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            PERIOD_EVT_OUT <= 1'b0;
        end else begin
            PERIOD_EVT_OUT <= is_single && period_match && period_evt_en_q;
        end
    end

    generate
        for (genvar p = 0; p < NPAIR; p++) begin : g_pulse
            // Active on run set; off at duty match
            always_ff @(posedge CORE_CLK_IN) begin
                if (RST_IN) begin
                    pulse_q[p] <= 1'b0;
                end else if (run_set) begin
                    pulse_q[p] <= 1'b1;
                end else if (timebase_run_q && (period_match ||
                             timebase_count_q == duty_value_q[p])) begin
                    pulse_q[p] <= 1'b0;
                end
            end

            assign odd_raw[p] = is_single ? pulse_q[p] :
                (timebase_run_q && timebase_count_q < duty_value_q[p]);
        end
    endgenerate

    assign ovr.sync_pt = timebase_count_q == '0 ||
        (is_center && timebase_count_q == period_value_q);
    assign ovr.shd_sel = override_select_q;
    assign ovr.shd_lvl = override_level_q;
    assign ovr.sync_en = override_sync_en_q;

    mpo_ovr_sync u_ovr_sync (
        .CLK_IN (CORE_CLK_IN),
        .RST_IN (RST_IN),
        .ovr    (ovr.syn)
    );

    // Two-flop synchronisers for async pins
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {DEBUG_HALT_IN, FAULT_B_IN, FAULT_A_IN};
            sync2_q <= sync1_q;
        end
    end

    assign fault_active = sync2_q[0] || sync2_q[1]
                          || (sync2_q[2] && breakpoint_fault_en_q);

    assign force_off = fault_active ?
        (fault_scope_all_q ? FLT_MASK_ALL : FLT_MASK_PART) : 8'h00;

    generate
        for (genvar p = 0; p < NPAIR; p++) begin : g_pair
            logic comp;
            logic odd_req;
            logic even_base;

            assign comp = !pair_mode_q[p];

            assign odd_req = ovr.act_sel[2*p+1] ? odd_raw[p]
                                                : ovr.act_lvl[2*p+1];
            assign even_base = comp ? !odd_req : odd_raw[p];

            // Even override active follows odd complement in complementary mode
            assign pin_req[2*p+1] = odd_req;
            assign pin_req[2*p]   = ovr.act_sel[2*p] ? even_base :
                (comp ? (ovr.act_lvl[2*p] && even_base)
                      : ovr.act_lvl[2*p]);

            mpo_pair_stage u_stage (
                .CLK_IN       (CORE_CLK_IN),
                .RST_IN       (RST_IN),
                .COMP_IN      (comp),
                .ODD_REQ_IN   (pin_req[2*p+1]),
                .EVEN_REQ_IN  (pin_req[2*p]),
                .DEAD_IN      (dead_time_q),
                .FORCE_OFF_IN (force_off[2*p +: 2]),
                .POL_IN       (POLARITY_IN[2*p +: 2]),
                .ACT_OUT      (pin_act[2*p +: 2]),
                .PIN_OUT      (PWM_OUT[2*p +: 2])
            );
        end
    endgenerate

endmodule : mpo_top
`default_nettype wire

// ### mpo_top_assertions.sv
// Port-level assertions for the PWM output block
`timescale 1ns/1ps
`default_nettype none
module mpo_top_assertions (
    input wire logic        CORE_CLK_IN,
    input wire logic        RST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic        PSLVERR_OUT,
    input wire logic        FAULT_A_IN,
    input wire logic        FAULT_B_IN,
    input wire logic        DEBUG_HALT_IN,
    input wire logic [7:0]  POLARITY_IN,
    input wire logic [7:0]  PWM_OUT,
    input wire logic        PERIOD_EVT_OUT
);
    import mpo_pkg::*;
    logic [7:0] ctl1_q;
    logic [7:0] sel_q;
    logic [7:0] lvl_q;
    logic [1:0] flt_q;
    logic [7:0] act;
    logic [3:0] both;
    logic       flt;
    logic       quiet;
    logic       bad_adr;
    assign act     = PWM_OUT ^ POLARITY_IN;
    assign flt     = FAULT_A_IN | FAULT_B_IN;
    assign bad_adr = PADDR_IN > OFS_DUTY3 || PADDR_IN[1:0] != 2'h0;
    assign both    = {act[7] & act[6], act[5] & act[4], act[3] & act[2],
                      act[1] & act[0]} & ~ctl1_q[7:4];
    assign quiet   = ctl1_q == 8'hF0 && sel_q == 8'h00 && !flt
                     && !(DEBUG_HALT_IN && flt_q[FLT_BRK_EN]);
    // Write shadow
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ctl1_q <= 8'h00;
            sel_q  <= RST_OVR_SEL;
            lvl_q  <= RST_OVR_LVL;
            flt_q  <= 2'h1;
        end else if (PSEL_IN && PENABLE_IN && PWRITE_IN) begin
            case (PADDR_IN)
                OFS_CTRL1:   ctl1_q <= PWDATA_IN[7:0];
                OFS_FLTCFG:  flt_q  <= PWDATA_IN[1:0];
                OFS_OVR_SEL: sel_q  <= PWDATA_IN[7:0];
                OFS_OVR_LVL: lvl_q  <= PWDATA_IN[7:0];
                default:     ;
            endcase
        end
    end
    default clocking dcb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    property p_no_overlap;
        both == 4'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("overlap");
    property p_flt_all;
        (flt && flt_q[FLT_SCOPE] && $stable(POLARITY_IN))[*5]
            |-> act == 8'h00;
    endproperty
    a_flt_all: assert property (p_flt_all) else $error("flt all");
    property p_flt_part;
        (flt && !flt_q[FLT_SCOPE] && ctl1_q == 8'hF0 && sel_q == 8'h00
            && $stable(lvl_q) && $stable(POLARITY_IN))[*5]
            |-> act == {lvl_q[7:6], 6'h00};
    endproperty
    a_flt_part: assert property (p_flt_part) else $error("flt part");
    property p_brk;
        (DEBUG_HALT_IN && flt_q[FLT_BRK_EN] && $stable(POLARITY_IN))[*5]
            |-> act[5:0] == 6'h00;
    endproperty
    a_brk: assert property (p_brk) else $error("brk");
    property p_direct;
        (quiet && $stable(lvl_q) && $stable(POLARITY_IN))[*5]
            |-> act == lvl_q;
    endproperty
    a_direct: assert property (p_direct) else $error("direct");
    property p_evt_one;
        PERIOD_EVT_OUT |=> !PERIOD_EVT_OUT;
    endproperty
    a_evt_one: assert property (p_evt_one) else $error("evt");
    property p_evt_idle;
        PERIOD_EVT_OUT && sel_q == 8'hFF && $stable(POLARITY_IN)
            |-> act == 8'h00;
    endproperty
    a_evt_idle: assert property (p_evt_idle) else $error("evt idle");
    property p_slverr;
        PSEL_IN && PENABLE_IN |-> PSLVERR_OUT == bad_adr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("slverr");
    c_evt: cover property (PERIOD_EVT_OUT);
    c_part: cover property (flt && !flt_q[FLT_SCOPE]);
    c_brk: cover property (DEBUG_HALT_IN && flt_q[FLT_BRK_EN]);
endmodule : mpo_top_assertions
`default_nettype wire

// ### mpo_top_tb.sv
// Self-checking bench for the PWM output block
`timescale 1ns/1ps
`default_nettype none
module mpo_top_tb;
    import mpo_pkg::*;
    logic        CORE_CLK_IN   = 1'b0;
    logic        RST_IN        = 1'b1;
    logic        PSEL_IN       = 1'b0;
    logic        PENABLE_IN    = 1'b0;
    logic        PWRITE_IN     = 1'b0;
    logic [7:0]  PADDR_IN      = 8'h00;
    logic [31:0] PWDATA_IN     = 32'h0;
    logic        FAULT_A_IN    = 1'b0;
    logic        FAULT_B_IN    = 1'b0;
    logic        DEBUG_HALT_IN = 1'b0;
    logic [7:0]  POLARITY_IN   = 8'h00;
    logic [3:0]  comp          = 4'hF;
    logic [31:0] PRDATA_OUT;
    logic        PREADY_OUT;
    logic        PSLVERR_OUT;
    logic        PERIOD_EVT_OUT;
    logic [7:0]  PWM_OUT;
    logic        shoot;
    logic [31:0] rd;
    logic        err;
    int          num_errors    = 0;
    int          total_checks  = 0;

    always #2 CORE_CLK_IN = ~CORE_CLK_IN;

    mpo_top u_mpo_top (.*);
    mpo_power_stage u_mpo_power_stage (
        .CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .PIN_IN(PWM_OUT),
        .POL_IN(POLARITY_IN), .COMP_IN(comp), .SHOOT_OUT(shoot));

    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK_IN);
    endtask : tick

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic pw(input logic [7:0] e);
        check("PWM_OUT", {24'h0, PWM_OUT}, {24'h0, e});
    endtask : pw

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        tick(1);
        PSEL_IN    <= 1'b1;
        PWRITE_IN  <= wr;
        PADDR_IN   <= a;
        PWDATA_IN  <= d;
        tick(1);
        PENABLE_IN <= 1'b1;
        do tick(1); while (PREADY_OUT !== 1'b1);
        rd = PRDATA_OUT;
        err = PSLVERR_OUT;
        PSEL_IN    <= 1'b0;
        PENABLE_IN <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd, e);
    endtask : rdc

    task automatic wait_evt;
        for (int n = 0; PERIOD_EVT_OUT !== 1'b1 && n < 100; n++) tick(1);
        check("PERIOD_EVT_OUT", {31'h0, PERIOD_EVT_OUT}, 32'h1);
    endtask : wait_evt

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        tick(20);
        RST_IN <= 1'b0;
        rdc(OFS_OVR_SEL, 32'hFF);
        rdc(OFS_OVR_LVL, 32'h00);
        rdc(OFS_FLTCFG, 32'h1);
        apb(1'b1, OFS_OVR_SEL, 32'h1FF);
        rdc(OFS_OVR_SEL, 32'hFF);
        apb(1'b0, 8'h30, 32'h0);
        check("PSLVERR_OUT", {31'h0, err}, 32'h1);
        check("unmapped", rd, 32'h0);
        $display("test registers done");
        apb(1'b1, OFS_OVR_SEL, 32'h00);
        apb(1'b1, OFS_OVR_LVL, 32'h03);
        tick(12);
        pw(8'h02);
        apb(1'b1, OFS_OVR_LVL, 32'h01);
        tick(4);
        pw(8'h00);
        tick(8);
        pw(8'h01);
        $display("test complementary done");
        apb(1'b1, OFS_CTRL1, 32'hF0);
        comp <= 4'h0;
        apb(1'b1, OFS_OVR_LVL, 32'hA5);
        tick(4);
        pw(8'hA5);
        POLARITY_IN <= 8'hFF;
        tick(3);
        pw(8'h5A);
        POLARITY_IN <= 8'h00;
        apb(1'b1, OFS_OVR_SEL, 32'h0F);
        tick(4);
        pw(8'hA0);
        apb(1'b1, OFS_OVR_SEL, 32'h00);
        apb(1'b1, OFS_OVR_LVL, 32'hFF);
        $display("test override done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_FLTCFG, {31'h0, i[1]});
            FAULT_A_IN <= !i[0];
            FAULT_B_IN <= i[0];
            tick(6);
            pw(i[1] ? 8'h00 : 8'hC0);
            FAULT_A_IN <= 1'b0;
            FAULT_B_IN <= 1'b0;
            tick(6);
            pw(8'hFF);
        end
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, OFS_FLTCFG, j ? 32'h3 : 32'h1);
            DEBUG_HALT_IN <= 1'b1;
            tick(6);
            pw(j ? 8'h00 : 8'hFF);
            DEBUG_HALT_IN <= 1'b0;
            tick(6);
        end
        $display("test fault done");
        apb(1'b1, OFS_OVR_SEL, 32'hFF);
        apb(1'b1, OFS_DUTY0, 32'h5);
        apb(1'b1, OFS_PERIOD, 32'h10);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFS_CTRL0, 32'h0D);
            tick(3);
            check("pin1", {31'h0, PWM_OUT[1]}, 32'h1);
            tick(9);
            check("pin1", {31'h0, PWM_OUT[1]}, 32'h0);
            wait_evt();
            rdc(OFS_CTRL0, 32'h09);
            rdc(OFS_PERIOD, 32'h10);
            rdc(OFS_DUTY0, 32'h5);
        end
        $display("test single pulse done");
        apb(1'b1, OFS_OVR_SEL, 32'h00);
        apb(1'b1, OFS_CTRL1, 32'hF1);
        apb(1'b1, OFS_PERIOD, 32'h40);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, OFS_CTRL0, 32'h0);
            apb(1'b1, OFS_CTRL0, m ? 32'h06 : 32'h04);
            tick(8);
            apb(1'b1, OFS_OVR_LVL, m ? 32'hFF : 32'h00);
            tick(3);
            pw(m ? 8'h00 : 8'hFF);
            tick(60);
            pw(m ? 8'hFF : 8'h00);
        end
        $display("test sync done");
        check("shoot", {31'h0, shoot}, 32'h0);
        wrap_up();
    end

    initial begin
        tick(5000);
        num_errors++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : mpo_top_tb
bind mpo_top mpo_top_assertions u_mpo_top_assertions (.*);
`default_nettype wire
